// ===== design/ddc_cfg.svh
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
// Functional notes
// - Each channel's sample either bypasses to serial output or is mixed.
// - Mixer multiplies real sample by selected oscillator's complex exponential.
// - Oscillator frequency set by a 32-bit frequency word.
// - Each channel has four oscillators: own word, phase offset, accumulator.
// - All four accumulators advance every cycle, selected or not.
// - A change on the two selection pins switches the active oscillator.
// - Pin change reaches mixer in about 36-40 cycles, sample in about 36.
// - Selection-source bit 1 takes index from the channel's two pins.
// - Selection-source bit 0 (default) takes index from software field.
// - Select value 00..11 maps to oscillator 0..3; unused source ignored.
// - Channel B replicates channel A, input picked by a binding field.
// - Each accumulator has its own word, plus optional shared rational divider.
// - Each accumulator has its own phase offset word.
// - Divider zero: frequency is word times 2^-32 times device clock.
// - 16-bit phase offset left-justified to 32 bits, added to accumulator.
// - Rewriting a word leaves phase non-deterministic until resync.
`define DDC_ACC_W 32
`define DDC_OFS_W 16
`define DDC_NUM_OSC 4
`define DDC_SMP_W 12
`define DDC_TRIG_W 16
`define DDC_PROD_W 28
`define DDC_SYNC_STAGES 3
`define DDC_SMP_LAT 36
`define DDC_SEL_LAT 33
`define DDC_SRC_PINS 1'b1
`define DDC_RDIV_W 16
`define DDC_RDIV_BASIC 16'h0000
`endif

// ===== design/ddc_pkg.sv
`include "ddc_cfg.svh"
package ddc_pkg;
  typedef logic [`DDC_ACC_W-1:0] acc_t;
  typedef logic [`DDC_OFS_W-1:0] ofs_t;
  typedef logic [1:0] osc_idx_t;
  typedef struct packed {
    acc_t [`DDC_NUM_OSC-1:0] freq_word;
    ofs_t [`DDC_NUM_OSC-1:0] phase_offset;
    osc_idx_t soft_osc_select;
  } chan_cfg_s;
  typedef struct packed {
    logic signed [`DDC_PROD_W-1:0] i;
    logic signed [`DDC_PROD_W-1:0] q;
  } iq_s;
endpackage

// ===== design/ddc_osc_channel.sv
`timescale 1ns/100ps
`include "ddc_cfg.svh"
// One channel: four free-running accumulators, selector, mixer.
module ddc_osc_channel #(
  parameter int SMP_LAT = `DDC_SMP_LAT,
  parameter int SEL_LAT = `DDC_SEL_LAT
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Configuration
  input wire ddc_pkg::chan_cfg_s i_cfg,
  input wire logic [`DDC_RDIV_W-1:0] i_rational_step_divider,
  input wire logic i_osc_select_source,
  // Pins, already in clock domain after sync
  input wire ddc_pkg::osc_idx_t i_pin_sel,
  // Samples
  input wire logic signed [`DDC_SMP_W-1:0] i_sample,
  output ddc_pkg::iq_s o_mix,
  output ddc_pkg::osc_idx_t o_active_osc
);
  ddc_pkg::acc_t acc [`DDC_NUM_OSC];
  logic [`DDC_RDIV_W-1:0] frac_cnt;
  logic frac_wrap;
  logic signed [`DDC_SMP_W-1:0] smp_dly [SMP_LAT];
  ddc_pkg::osc_idx_t sel_dly [SEL_LAT];
  ddc_pkg::osc_idx_t next_sel;
  ddc_pkg::acc_t phase;
  logic signed [`DDC_TRIG_W-1:0] cos_v;
  logic signed [`DDC_TRIG_W-1:0] sin_v;

  // Coarse quadrant-plus-linear approximation; a full table would blow the area budget.
  function automatic logic signed [`DDC_TRIG_W-1:0] approx_cos(input ddc_pkg::acc_t p);
    logic [`DDC_TRIG_W-1:0] ramp;
    ramp = {1'b0, p[`DDC_ACC_W-3 -: `DDC_TRIG_W-1]};
    unique case (p[`DDC_ACC_W-1 -: 2])
      2'b00: approx_cos = $signed(16'h7fff - ramp);
      2'b01: approx_cos = -$signed(ramp);
      2'b10: approx_cos = $signed(ramp) - $signed(16'h7fff);
      2'b11: approx_cos = $signed(ramp);
    endcase
  endfunction

  // Rational mode: divider counts samples; at zero the accumulators run basic
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      frac_cnt <= '0;
    end else if (i_rational_step_divider == `DDC_RDIV_BASIC ||
                 frac_cnt == i_rational_step_divider - 16'h0001) begin
      frac_cnt <= '0;
    end else begin
      frac_cnt <= frac_cnt + 16'h0001;
    end
  end
  assign frac_wrap = (i_rational_step_divider != `DDC_RDIV_BASIC) &&
                     (frac_cnt == i_rational_step_divider - 16'h0001);

  // Word rewrites take effect at once; phase is not resynchronised
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < `DDC_NUM_OSC; k++) acc[k] <= '0;
    end else begin
      for (int k = 0; k < `DDC_NUM_OSC; k++) begin
        // Modulo 2^32 wrap by plain truncation
        acc[k] <= acc[k] + i_cfg.freq_word[k] + {31'h0, frac_wrap};
      end
    end
  end

  always_comb begin
    if (i_osc_select_source == `DDC_SRC_PINS) begin
      next_sel = i_pin_sel;
    end else begin
      next_sel = i_cfg.soft_osc_select;
    end
  end

  // Delay lines align pin and sample latency to the mixer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < SMP_LAT; k++) smp_dly[k] <= '0;
      for (int k = 0; k < SEL_LAT; k++) sel_dly[k] <= '0;
    end else begin
      smp_dly[0] <= i_sample;
      sel_dly[0] <= next_sel;
      for (int k = 1; k < SMP_LAT; k++) smp_dly[k] <= smp_dly[k-1];
      for (int k = 1; k < SEL_LAT; k++) sel_dly[k] <= sel_dly[k-1];
    end
  end

  // Binary index straight into the bank
  assign phase = acc[sel_dly[SEL_LAT-1]] +
                 {i_cfg.phase_offset[sel_dly[SEL_LAT-1]], 16'h0000};
  assign cos_v = approx_cos(phase);
  assign sin_v = approx_cos(phase - 32'h40000000);

  // x * e^{jwn}: I = x cos, Q = x sin
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mix <= '0;
      o_active_osc <= '0;
    end else begin
      o_mix.i <= smp_dly[SMP_LAT-1] * cos_v;
      o_mix.q <= smp_dly[SMP_LAT-1] * sin_v;
      o_active_osc <= sel_dly[SEL_LAT-1];
    end
  end
endmodule

// ===== design/ddc_nco_bank_and_mixer.sv
`timescale 1ns/100ps
`include "ddc_cfg.svh"
module ddc_nco_bank_and_mixer (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Converter samples
  input wire logic signed [`DDC_SMP_W-1:0] i_sample_a,
  input wire logic signed [`DDC_SMP_W-1:0] i_sample_b,
  // Configuration
  input wire logic i_osc_select_source,
  input wire logic i_ddc_bypass,
  input wire logic i_chan_b_input_binding,
  input wire logic [`DDC_RDIV_W-1:0] i_rational_step_divider,
  input wire ddc_pkg::chan_cfg_s i_chan_a_cfg,
  input wire ddc_pkg::chan_cfg_s i_chan_b_cfg,
  // Hop pins
  input wire logic i_chan_a_hop_pin_lo,
  input wire logic i_chan_a_hop_pin_hi,
  input wire logic i_chan_b_hop_pin_lo,
  input wire logic i_chan_b_hop_pin_hi,
  // Outputs
  output ddc_pkg::iq_s o_chan_a_mix,
  output ddc_pkg::iq_s o_chan_b_mix,
  output logic signed [`DDC_SMP_W-1:0] o_bypass_a,
  output logic signed [`DDC_SMP_W-1:0] o_bypass_b,
  output logic o_bypass_active,
  output ddc_pkg::osc_idx_t o_chan_a_active_osc,
  output ddc_pkg::osc_idx_t o_chan_b_active_osc
);
  logic [1:0] pin_sync_a [`DDC_SYNC_STAGES];
  logic [1:0] pin_sync_b [`DDC_SYNC_STAGES];
  logic signed [`DDC_SMP_W-1:0] src_b;

  // Pins are asynchronous; stage 0 is read only by stage 1
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < `DDC_SYNC_STAGES; k++) begin
        pin_sync_a[k] <= '0;
        pin_sync_b[k] <= '0;
      end
    end else begin
      pin_sync_a[0] <= {i_chan_a_hop_pin_hi, i_chan_a_hop_pin_lo};
      pin_sync_b[0] <= {i_chan_b_hop_pin_hi, i_chan_b_hop_pin_lo};
      for (int k = 1; k < `DDC_SYNC_STAGES; k++) begin
        pin_sync_a[k] <= pin_sync_a[k-1];
        pin_sync_b[k] <= pin_sync_b[k-1];
      end
    end
  end

  assign src_b = i_chan_b_input_binding ? i_sample_a : i_sample_b;

  ddc_osc_channel u_chan_a (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_cfg(i_chan_a_cfg),
    .i_rational_step_divider(i_rational_step_divider),
    .i_osc_select_source(i_osc_select_source),
    .i_pin_sel(pin_sync_a[`DDC_SYNC_STAGES-1]),
    .i_sample(i_sample_a),
    .o_mix(o_chan_a_mix),
    .o_active_osc(o_chan_a_active_osc)
  );

  ddc_osc_channel u_chan_b (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_cfg(i_chan_b_cfg),
    .i_rational_step_divider(i_rational_step_divider),
    .i_osc_select_source(i_osc_select_source),
    .i_pin_sel(pin_sync_b[`DDC_SYNC_STAGES-1]),
    .i_sample(src_b),
    .o_mix(o_chan_b_mix),
    .o_active_osc(o_chan_b_active_osc)
  );

  // Bypass path registered once; mixer path keeps running regardless
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bypass_a <= '0;
      o_bypass_b <= '0;
      o_bypass_active <= 1'b0;
    end else begin
      o_bypass_a <= i_ddc_bypass ? i_sample_a : '0;
      o_bypass_b <= i_ddc_bypass ? src_b : '0;
      o_bypass_active <= i_ddc_bypass;
    end
  end
endmodule

// ===== test/ddc_nco_bank_and_mixer_properties.sv
`timescale 1ns/100ps
`include "ddc_cfg.svh"
module ddc_nco_bank_and_mixer_properties (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic signed [`DDC_SMP_W-1:0] i_sample_a,
  input wire logic signed [`DDC_SMP_W-1:0] i_sample_b,
  input wire logic i_osc_select_source,
  input wire logic i_ddc_bypass,
  input wire logic i_chan_b_input_binding,
  input wire ddc_pkg::chan_cfg_s i_chan_a_cfg,
  input wire ddc_pkg::chan_cfg_s i_chan_b_cfg,
  input wire logic i_chan_a_hop_pin_lo,
  input wire logic i_chan_a_hop_pin_hi,
  input wire logic i_chan_b_hop_pin_lo,
  input wire logic i_chan_b_hop_pin_hi,
  input wire ddc_pkg::iq_s o_chan_a_mix,
  input wire ddc_pkg::iq_s o_chan_b_mix,
  input wire logic signed [`DDC_SMP_W-1:0] o_bypass_a,
  input wire logic signed [`DDC_SMP_W-1:0] o_bypass_b,
  input wire logic o_bypass_active,
  input wire ddc_pkg::osc_idx_t o_chan_a_active_osc,
  input wire ddc_pkg::osc_idx_t o_chan_b_active_osc
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [1:0] want_a, want_b, prev_a, prev_b;
  logic [5:0] calm_a, calm_b;
  logic signed [`DDC_SMP_W-1:0] smp_b;
  assign want_a = i_osc_select_source ? {i_chan_a_hop_pin_hi, i_chan_a_hop_pin_lo}
    : i_chan_a_cfg.soft_osc_select;
  assign want_b = i_osc_select_source ? {i_chan_b_hop_pin_hi, i_chan_b_hop_pin_lo}
    : i_chan_b_cfg.soft_osc_select;
  assign smp_b = i_chan_b_input_binding ? i_sample_a : i_sample_b;
  // Cycles since the wanted index last moved; saturates so it never wraps back
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {prev_a, prev_b, calm_a, calm_b} <= '0;
    end else begin
      {prev_a, prev_b} <= {want_a, want_b};
      calm_a <= (want_a != prev_a) ? 6'h00 : calm_a + {5'h00, calm_a != 6'h3f};
      calm_b <= (want_b != prev_b) ? 6'h00 : calm_b + {5'h00, calm_b != 6'h3f};
    end
  end
  property p_flag; 1 |=> o_bypass_active == $past(i_ddc_bypass); endproperty
  a_flag: assert property (p_flag) else $error("bypass flag wrong");
  property p_byp_a; 1 |=> o_bypass_a == ($past(i_ddc_bypass) ? $past(i_sample_a) : '0); endproperty
  a_byp_a: assert property (p_byp_a) else $error("bypass a wrong");
  property p_byp_b; 1 |=> o_bypass_b == ($past(i_ddc_bypass) ? $past(smp_b) : '0); endproperty
  a_byp_b: assert property (p_byp_b) else $error("bypass b wrong");
  // Counter reads two below the edge count since the change; 38 leaves margin
  property p_sel_a; want_a == prev_a && calm_a >= 6'd38 |-> o_chan_a_active_osc == want_a;
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("osc a select wrong");
  property p_sel_b; want_b == prev_b && calm_b >= 6'd38 |-> o_chan_b_active_osc == want_b;
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("osc b select wrong");
  property p_hold_a; want_a != prev_a && calm_a >= 6'd38 |-> $stable(o_chan_a_active_osc)[*8];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("osc a switched early");
  property p_mix_a; $past(i_sample_a, 36) == 0 && $past(i_sample_a, 37) == 0
    && $past(i_sample_a, 38) == 0 |-> o_chan_a_mix == '0; endproperty
  a_mix_a: assert property (p_mix_a) else $error("mix a not zero");
  property p_mix_b; $past(smp_b, 36) == 0 && $past(smp_b, 37) == 0
    && $past(smp_b, 38) == 0 |-> o_chan_b_mix == '0; endproperty
  a_mix_b: assert property (p_mix_b) else $error("mix b not zero");
endmodule

// ===== test/converter_core_model.sv
`timescale 1ns/100ps
`include "ddc_cfg.svh"
// Converter side: a fresh sample every cycle, a held level, or exact zeros when quiet
module converter_core_model (
  input wire logic i_ref_clk,
  input wire logic i_quiet,
  input wire logic i_hold,
  output logic signed [`DDC_SMP_W-1:0] o_sample_a,
  output logic signed [`DDC_SMP_W-1:0] o_sample_b
);
  initial {o_sample_a, o_sample_b} = '0;
  always @(negedge i_ref_clk) begin
    o_sample_a <= i_quiet ? '0 : o_sample_a + (i_hold ? 12'sh000 : 12'sh0a7);
    o_sample_b <= i_quiet ? '0 : o_sample_b - (i_hold ? 12'sh000 : 12'sh133);
  end
endmodule

// ===== test/tb_ddc_nco_bank_and_mixer.sv
`timescale 1ns/100ps
`include "ddc_cfg.svh"
module tb_ddc_nco_bank_and_mixer;
  logic i_ref_clk, i_nrst, i_osc_select_source, i_ddc_bypass, i_chan_b_input_binding, quiet;
  logic hold;
  logic signed [`DDC_PROD_W-1:0] em;
  logic i_chan_a_hop_pin_lo, i_chan_a_hop_pin_hi, i_chan_b_hop_pin_lo, i_chan_b_hop_pin_hi;
  logic [`DDC_RDIV_W-1:0] i_rational_step_divider;
  ddc_pkg::chan_cfg_s i_chan_a_cfg, i_chan_b_cfg;
  logic signed [`DDC_SMP_W-1:0] i_sample_a, i_sample_b, o_bypass_a, o_bypass_b, ea, eb;
  ddc_pkg::iq_s o_chan_a_mix, o_chan_b_mix;
  ddc_pkg::osc_idx_t o_chan_a_active_osc, o_chan_b_active_osc;
  logic o_bypass_active;
  int errors, n_compared;
  ddc_nco_bank_and_mixer dut_u (.*);
  converter_core_model pm_u (.i_ref_clk(i_ref_clk), .i_quiet(quiet), .i_hold(hold),
    .o_sample_a(i_sample_a), .o_sample_b(i_sample_b));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    i_ref_clk = 0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #16000;
    errors++;
    finish_test();
  end
  initial begin
    {i_nrst, i_osc_select_source, i_ddc_bypass, i_chan_b_input_binding, quiet, hold} = '0;
    {i_chan_a_hop_pin_hi, i_chan_a_hop_pin_lo, i_chan_b_hop_pin_hi, i_chan_b_hop_pin_lo} = '0;
    {i_rational_step_divider, i_chan_a_cfg, i_chan_b_cfg} = '0;
    for (int n = 0; n < 4; n++) begin
      // Oscillator A0 stands still, so its phase is known from its offset alone
      i_chan_a_cfg.freq_word[n] = (n == 0) ? 32'h0 : 32'h0100_0000 << n;
      i_chan_b_cfg.freq_word[n] = 32'h0030_0000 << n;
      i_chan_b_cfg.phase_offset[n] = 16'h1000 << n;
    end
    cyc(8);
    i_nrst = 1;
    i_ddc_bypass = 1;
    for (int b = 0; b < 2; b++) begin
      i_chan_b_input_binding = b[0];
      cyc(2);
      repeat (3) begin
        @(posedge i_ref_clk);
        ea = i_sample_a;
        eb = b ? i_sample_a : i_sample_b;
        @(negedge i_ref_clk);
        chk("bypass_a", ea, o_bypass_a);
        chk("bypass_b", eb, o_bypass_b);
      end
    end
    i_ddc_bypass = 0;
    cyc(2);
    chk("bypass_off", '0, {o_bypass_active, o_bypass_a, o_bypass_b});
    // Unused source carries the opposite index so a wrong pick shows
    for (int s = 0; s < 2; s++) begin
      for (int v = 0; v < 4; v++) begin
        i_osc_select_source = s[0];
        i_chan_a_cfg.soft_osc_select = s ? ~v[1:0] : v[1:0];
        i_chan_b_cfg.soft_osc_select = s ? v[1:0] : ~v[1:0];
        {i_chan_a_hop_pin_hi, i_chan_a_hop_pin_lo} = s ? v[1:0] : ~v[1:0];
        {i_chan_b_hop_pin_hi, i_chan_b_hop_pin_lo} = s ? ~v[1:0] : v[1:0];
        cyc(40);
        chk("osc_a", v[1:0], o_chan_a_active_osc);
        chk("osc_b", 2'(~v[1:0]), o_chan_b_active_osc);
      end
    end
    {i_chan_a_hop_pin_hi, i_chan_a_hop_pin_lo} = 2'h0;
    cyc(34);
    chk("osc_a_early", 2'h3, o_chan_a_active_osc);
    cyc(6);
    chk("osc_a_late", 2'h0, o_chan_a_active_osc);
    // Held level through the pipe; full-scale oscillator amplitude is 0x7fff
    hold = 1;
    cyc(40);
    ea = i_sample_a;
    em = ea * 16'sh7fff;
    chk("mix_cos", {em, 28'h0000000}, o_chan_a_mix);
    i_chan_a_cfg.phase_offset[0] = 16'h4000;
    cyc(2);
    chk("mix_sin", {28'h0000000, em}, o_chan_a_mix);
    quiet = 1;
    i_rational_step_divider = 16'h0780;
    cyc(45);
    chk("mix_a", '0, o_chan_a_mix);
    chk("mix_b", '0, o_chan_b_mix);
    finish_test();
  end
endmodule
bind ddc_nco_bank_and_mixer ddc_nco_bank_and_mixer_properties prop_u (.*);
